/* rtl/lsel_pkg.sv */
package lsel_pkg;
  localparam int NUM_CH = 4;
  localparam int NUM_SRC = 7;
  localparam int CLK_MHZ = 200;
  // register indices inside one channel; byte address is four times the index
  localparam logic [5:0] IDX_MASK = 6'h11;
  localparam logic [5:0] IDX_EDGE_SEL = 6'h13;
  localparam logic [5:0] IDX_LIVE = 6'h14;
  localparam logic [5:0] IDX_LOOP_STAT = 6'h15;
  localparam logic [5:0] IDX_INT_STAT = 6'h16;
  localparam logic [5:0] IDX_CTRL = 6'h18;
  localparam logic [5:0] IDX_INT_CLEAR = 6'h19;
  localparam int IDX_W = 8;
  localparam int CH_LSB = 6;
  // source bit positions, then loop status and control bit positions
  localparam int BIT_LOOP_UP = 6;
  localparam int BIT_LOOP_DOWN = 5;
  localparam int BIT_PATTERN = 4;
  localparam int BIT_TX_CLK = 3;
  localparam int BIT_DRIVER = 2;
  localparam int BIT_AIS = 1;
  localparam int BIT_NO_SIG = 0;
  localparam int BIT_LOOP_ACTIVE = 5;
  localparam int BIT_AUTO_LOOP = 0;
  localparam logic [6:0] EDGE_SEL_RESET = 7'h00;
  localparam logic [6:0] MASK_RESET = 7'h7f;
  // code persistence times
  localparam int CODE_TIME_SHORT_MS = 40;
  localparam int CODE_TIME_LONG_MS = 5100;
  localparam longint CODE_CYC_SHORT = longint'(CODE_TIME_SHORT_MS) * CLK_MHZ * 1000;
  localparam longint CODE_CYC_LONG = longint'(CODE_TIME_LONG_MS) * CLK_MHZ * 1000;
  localparam int CODE_CNT_W = 31;
  // transmit clock stall limit in master clock cycles
  localparam int TX_STALL_CYC = 70;
  localparam int TX_CNT_W = 7;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  typedef enum logic [1:0] {BusIdle, BusWrite, BusReadWait, BusReadDone} lsel_bus_type;
endpackage

/* rtl/line_status_event_logic.sv */
// Notes on behaviour
// RULE1: seven edge-select bits, reset zero, bit seven reserved
// RULE2: select zero: only rising status edge counts
// RULE3: select one: rising and falling edges count
// RULE4: interrupt only while source mask bit clear
// RULE5: code seen after 40 ms or 5.1 s
// RULE6: code bit holds while error rate low
// RULE7: loop-up rising edge closes remote loopback
// RULE8: loop-down rising edge opens remote loopback
// RULE9: pattern sync bit follows receiver sync live
// RULE10: tx clock missing after 70 idle cycles
// RULE11: driver fault bit follows short circuit detect
// RULE12: live status read-only, zero after reset
// RULE13: edge-select per channel at 13H..D3H
// RULE14: live status per channel at 14H..D4H
// RULE15: alarm and signal loss bits follow detectors
// RULE16: mask bits reset to one, masked
// RULE17: qualified event latches, cleared by read
// RULE18: edges found against previous cycle sample
// RULE19: channel request high while latched bit set
//
// Local design decision: register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
module line_status_event_logic #(
  parameter int NCH = lsel_pkg::NUM_CH,
  parameter longint CODE_CYC_SHORT = lsel_pkg::CODE_CYC_SHORT,
  parameter longint CODE_CYC_LONG = lsel_pkg::CODE_CYC_LONG,
  parameter int TX_STALL_CYC = lsel_pkg::TX_STALL_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic [NCH-1:0] loopUpCodeMatch,
  input wire logic [NCH-1:0] loopDownCodeMatch,
  input wire logic [NCH-1:0] codeErrorRateHigh,
  input wire logic [NCH-1:0] patternSyncIn,
  input wire logic [NCH-1:0] tx_clock_input,
  input wire logic [NCH-1:0] driverShortIn,
  input wire logic [NCH-1:0] alarmIndicationIn,
  input wire logic [NCH-1:0] noSignalIn,
  output logic [NCH-1:0] remoteLoopbackActive,
  output logic [NCH-1:0] channelIrq,
  output logic irq
);
  localparam int NS = lsel_pkg::NUM_SRC;
  localparam int CW = lsel_pkg::CODE_CNT_W;
  localparam int TW = lsel_pkg::TX_CNT_W;
  localparam logic [CW-1:0] CODE_SHORT = CW'(CODE_CYC_SHORT);
  localparam logic [CW-1:0] CODE_LONG = CW'(CODE_CYC_LONG);
  localparam logic [TW-1:0] TX_LIMIT = TW'(TX_STALL_CYC);

  lsel_pkg::lsel_bus_type busState_q;
  lsel_pkg::lsel_bus_type busState_d;
  logic [lsel_pkg::IDX_W-1:0] busIdx_q;
  logic [31:0] hrdata_q;
  logic [NS-1:0] edgeSel_q [NCH];
  logic [NS-1:0] mask_q [NCH];
  logic [NS-1:0] intStat_q [NCH];
  logic [NCH-1:0] autoLoop_q;
  logic [NS-1:0] live [NCH];
  logic [NS-1:0] livePrev_q [NCH];
  logic [NS-1:0] event_w [NCH];
  logic [NCH-1:0] loopUpSeen_q;
  logic [NCH-1:0] loopDownSeen_q;
  logic [NCH-1:0] patternSync_q;
  logic [NCH-1:0] txMissing_q;
  logic [NCH-1:0] driverFault_q;
  logic [NCH-1:0] alarmInd_q;
  logic [NCH-1:0] noSignal_q;
  logic [NCH-1:0] txPrev_q;
  logic [NCH-1:0] remoteLoop_q;
  logic [CW-1:0] upCnt_q [NCH];
  logic [CW-1:0] downCnt_q [NCH];
  logic [TW-1:0] txCnt_q [NCH];
  logic addrPhase;
  logic [lsel_pkg::IDX_W-1:0] reqIdx;
  logic [1:0] wrCh;
  logic [5:0] wrReg;
  logic [1:0] rdCh;
  logic [5:0] rdReg;
  logic doWrite;
  logic doRead;
  logic [31:0] readWord;

  // bus slave: writes take no wait state, reads one so that hrdata comes from a flop
  assign addrPhase = hsel && hready && (htrans == lsel_pkg::HTRANS_NONSEQ);
  assign reqIdx = haddr[lsel_pkg::IDX_W+1:2];
  assign wrCh = busIdx_q[lsel_pkg::IDX_W-1:lsel_pkg::CH_LSB];
  assign wrReg = busIdx_q[lsel_pkg::CH_LSB-1:0];
  assign rdCh = wrCh;
  assign rdReg = wrReg;
  assign doWrite = (busState_q == lsel_pkg::BusWrite);
  assign doRead = (busState_q == lsel_pkg::BusReadWait);
  assign hreadyout = (busState_q != lsel_pkg::BusReadWait);
  assign hresp = 1'b0;
  assign hrdata = hrdata_q;

  always_comb begin
    busState_d = lsel_pkg::BusIdle;
    case (busState_q)
      lsel_pkg::BusReadWait: begin
        busState_d = lsel_pkg::BusReadDone;
      end
      default: begin
        if (addrPhase) begin
          busState_d = hwrite ? lsel_pkg::BusWrite : lsel_pkg::BusReadWait;
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      busState_q <= lsel_pkg::BusIdle;
    end else begin
      busState_q <= busState_d;
    end
  end

  // index kept for the data phase, when haddr may already name the next transfer
  always_ff @(posedge clk) begin
    if (rst) begin
      busIdx_q <= '0;
    end else if (addrPhase && hreadyout) begin
      busIdx_q <= reqIdx;
    end
  end

  // read mux; unmapped addresses and reserved bits read zero
  always_comb begin
    readWord = '0;
    if (int'(rdCh) < NCH) begin
      case (rdReg)
        lsel_pkg::IDX_MASK: readWord[NS-1:0] = mask_q[rdCh];
        lsel_pkg::IDX_EDGE_SEL: readWord[NS-1:0] = edgeSel_q[rdCh]; // see RULE13
        lsel_pkg::IDX_LIVE: readWord[NS-1:0] = live[rdCh]; // see RULE14
        lsel_pkg::IDX_LOOP_STAT: readWord[lsel_pkg::BIT_LOOP_ACTIVE] = remoteLoop_q[rdCh];
        lsel_pkg::IDX_INT_STAT: readWord[NS-1:0] = intStat_q[rdCh];
        lsel_pkg::IDX_CTRL: readWord[lsel_pkg::BIT_AUTO_LOOP] = autoLoop_q[rdCh];
        default: readWord = '0;
      endcase
    end
  end

  // captured in the wait state, so hrdata never depends on haddr combinationally
  always_ff @(posedge clk) begin
    if (rst) begin
      hrdata_q <= '0;
    end else if (doRead) begin
      hrdata_q <= readWord;
    end
  end

  genvar c;
  generate
    for (c = 0; c < NCH; c++) begin : g_ch
      logic selWr;
      logic wrEdgeSel;
      logic wrMask;
      logic wrCtrl;
      logic wrClear;
      logic rdClear;
      logic [CW-1:0] codeLimit;
      logic upAtLimit;
      logic downAtLimit;
      logic txToggled;
      logic upRise;
      logic downRise;
      logic [NS-1:0] riseEv;
      logic [NS-1:0] fallEv;
      logic [NS-1:0] qualified;
      logic [NS-1:0] clearBits;
      assign selWr = doWrite && (int'(wrCh) == c);
      assign wrEdgeSel = selWr && (wrReg == lsel_pkg::IDX_EDGE_SEL);
      assign wrMask = selWr && (wrReg == lsel_pkg::IDX_MASK);
      assign wrCtrl = selWr && (wrReg == lsel_pkg::IDX_CTRL);
      assign wrClear = selWr && (wrReg == lsel_pkg::IDX_INT_CLEAR);
      // the read that returns the status word is also the one that empties it
      assign rdClear = doRead && (int'(rdCh) == c) && (rdReg == lsel_pkg::IDX_INT_STAT);
      assign codeLimit = autoLoop_q[c] ? CODE_LONG : CODE_SHORT;
      assign upAtLimit = (upCnt_q[c] >= codeLimit);
      assign downAtLimit = (downCnt_q[c] >= codeLimit);
      assign txToggled = (tx_clock_input[c] != txPrev_q[c]);

      // software registers
      always_ff @(posedge clk) begin
        if (rst) begin
          edgeSel_q[c] <= lsel_pkg::EDGE_SEL_RESET; // see RULE1
        end else if (wrEdgeSel) begin
          edgeSel_q[c] <= hwdata[NS-1:0]; // see RULE1
        end
      end

      // mask doubles as the enable register with the sense inverted
      always_ff @(posedge clk) begin
        if (rst) begin
          mask_q[c] <= lsel_pkg::MASK_RESET; // see RULE16
        end else if (wrMask) begin
          mask_q[c] <= hwdata[NS-1:0]; // see RULE4
        end
      end

      always_ff @(posedge clk) begin
        if (rst) begin
          autoLoop_q[c] <= 1'b0;
        end else if (wrCtrl) begin
          autoLoop_q[c] <= hwdata[lsel_pkg::BIT_AUTO_LOOP];
        end
      end

      // loop codes must persist for the full time before the bit rises;
      // once up, only a high error rate (code gone) drops it
      always_ff @(posedge clk) begin
        if (rst) begin
          upCnt_q[c] <= '0;
          loopUpSeen_q[c] <= 1'b0;
        end else if (loopUpSeen_q[c]) begin
          upCnt_q[c] <= '0;
          if (codeErrorRateHigh[c]) begin
            loopUpSeen_q[c] <= 1'b0; // see RULE6
          end
        end else if (!loopUpCodeMatch[c]) begin
          upCnt_q[c] <= '0;
        end else if (upAtLimit) begin
          loopUpSeen_q[c] <= 1'b1; // see RULE5
        end else begin
          upCnt_q[c] <= upCnt_q[c] + 1'b1;
        end
      end

      always_ff @(posedge clk) begin
        if (rst) begin
          downCnt_q[c] <= '0;
          loopDownSeen_q[c] <= 1'b0;
        end else if (loopDownSeen_q[c]) begin
          downCnt_q[c] <= '0;
          if (codeErrorRateHigh[c]) begin
            loopDownSeen_q[c] <= 1'b0; // see RULE6
          end
        end else if (!loopDownCodeMatch[c]) begin
          downCnt_q[c] <= '0;
        end else if (downAtLimit) begin
          loopDownSeen_q[c] <= 1'b1; // see RULE5
        end else begin
          downCnt_q[c] <= downCnt_q[c] + 1'b1;
        end
      end

      always_ff @(posedge clk) begin
        if (rst) begin
          txPrev_q[c] <= 1'b0;
        end else begin
          txPrev_q[c] <= tx_clock_input[c];
        end
      end

      // transmit clock watchdog; counter saturates so a dead clock stays flagged
      always_ff @(posedge clk) begin
        if (rst) begin
          txCnt_q[c] <= '0;
          txMissing_q[c] <= 1'b0;
        end else begin
          if (txToggled) begin
            txCnt_q[c] <= '0;
            txMissing_q[c] <= 1'b0; // see RULE10
          end else if (txCnt_q[c] >= TX_LIMIT) begin
            txMissing_q[c] <= 1'b1; // see RULE10
          end else begin
            txCnt_q[c] <= txCnt_q[c] + 1'b1;
          end
        end
      end

      // live detector levels, one flop each
      always_ff @(posedge clk) begin
        if (rst) begin
          patternSync_q[c] <= 1'b0;
        end else begin
          patternSync_q[c] <= patternSyncIn[c]; // see RULE9
        end
      end

      always_ff @(posedge clk) begin
        if (rst) begin
          driverFault_q[c] <= 1'b0;
        end else begin
          driverFault_q[c] <= driverShortIn[c]; // see RULE11
        end
      end

      always_ff @(posedge clk) begin
        if (rst) begin
          alarmInd_q[c] <= 1'b0;
        end else begin
          alarmInd_q[c] <= alarmIndicationIn[c]; // see RULE15
        end
      end

      always_ff @(posedge clk) begin
        if (rst) begin
          noSignal_q[c] <= 1'b0;
        end else begin
          noSignal_q[c] <= noSignalIn[c]; // see RULE15
        end
      end

      // live status is never latched and has no write path
      always_comb begin
        live[c] = '0;
        live[c][lsel_pkg::BIT_LOOP_UP] = loopUpSeen_q[c];
        live[c][lsel_pkg::BIT_LOOP_DOWN] = loopDownSeen_q[c];
        live[c][lsel_pkg::BIT_PATTERN] = patternSync_q[c];
        live[c][lsel_pkg::BIT_TX_CLK] = txMissing_q[c];
        live[c][lsel_pkg::BIT_DRIVER] = driverFault_q[c];
        live[c][lsel_pkg::BIT_AIS] = alarmInd_q[c];
        live[c][lsel_pkg::BIT_NO_SIG] = noSignal_q[c]; // see RULE12
      end

      always_ff @(posedge clk) begin
        if (rst) begin
          livePrev_q[c] <= '0;
        end else begin
          livePrev_q[c] <= live[c]; // see RULE18
        end
      end

      // rising always counts; falling counts only where edge select is set
      assign riseEv = live[c] & ~livePrev_q[c]; // see RULE2
      assign fallEv = edgeSel_q[c] & livePrev_q[c] & ~live[c]; // see RULE3
      assign event_w[c] = riseEv | fallEv; // see RULE18

      assign upRise = loopUpSeen_q[c] && !livePrev_q[c][lsel_pkg::BIT_LOOP_UP];
      assign downRise = loopDownSeen_q[c] && !livePrev_q[c][lsel_pkg::BIT_LOOP_DOWN];

      // if both rise together the deactivate wins: opening the loop is the safe side
      always_ff @(posedge clk) begin
        if (rst) begin
          remoteLoop_q[c] <= 1'b0;
        end else if (downRise) begin
          remoteLoop_q[c] <= 1'b0; // see RULE8
        end else if (upRise) begin
          remoteLoop_q[c] <= 1'b1; // see RULE7
        end
      end

      // masked events are dropped, not latched, so unmasking raises nothing stale
      assign qualified = event_w[c] & ~mask_q[c]; // see RULE4
      assign clearBits = rdClear ? {NS{1'b1}} : (wrClear ? hwdata[NS-1:0] : '0);

      // latched events; a new event in the clearing cycle survives the clear
      always_ff @(posedge clk) begin
        if (rst) begin
          intStat_q[c] <= '0;
        end else begin
          intStat_q[c] <= (intStat_q[c] & ~clearBits) | qualified; // see RULE17
        end
      end

      assign channelIrq[c] = |intStat_q[c]; // see RULE19
      assign remoteLoopbackActive[c] = remoteLoop_q[c];
    end
  endgenerate

  assign irq = |channelIrq;

  logic unusedBits;
  assign unusedBits = ^{haddr[31:lsel_pkg::IDX_W+2], haddr[1:0], hsize, hwdata[31:NS]};
endmodule
`default_nettype wire

/* verif/lsel_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module lsel_asserts #(
  parameter longint CODE_CYC_SHORT = 20,
  parameter int NCH = 4
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  input wire logic [NCH-1:0] loopUpCodeMatch,
  input wire logic [NCH-1:0] remoteLoopbackActive,
  input wire logic [NCH-1:0] channelIrq,
  input wire logic irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic take;
  logic [31:0] runLen_q;
  logic [31:0] peakLen_q;
  assign take = hsel & hready & (htrans == lsel_pkg::HTRANS_NONSEQ);
  // longest unbroken loop-up run; half margin keeps the pipeline latency out
  always_ff @(posedge clk) begin
    if (rst) begin
      runLen_q <= '0;
      peakLen_q <= '0;
    end else begin
      runLen_q <= loopUpCodeMatch[NCH-1] ? runLen_q + 32'h1 : 32'h0;
      if (runLen_q > peakLen_q) peakLen_q <= runLen_q;
    end
  end
  property p_okay; hresp == 1'b0; endproperty
  a_okay: assert property (p_okay) else $error("error response seen");
  property p_irq_or; irq == |channelIrq; endproperty
  a_irq_or: assert property (p_irq_or) else $error("irq not or of channels");
  property p_read_wait; take && !hwrite |=> !hreadyout ##1 hreadyout; endproperty
  a_read_wait: assert property (p_read_wait) else $error("read wait wrong");
  property p_write_nowait; take && hwrite |=> hreadyout; endproperty
  a_write_nowait: assert property (p_write_nowait) else $error("write stalled");
  property p_low_once; !hreadyout |=> hreadyout; endproperty
  a_low_once: assert property (p_low_once) else $error("ready low too long");
  property p_rdata_hold; hreadyout |=> $stable(hrdata); endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
  property p_loop_time;
    $rose(remoteLoopbackActive[NCH-1]) |-> peakLen_q >= CODE_CYC_SHORT / 2;
  endproperty
  a_loop_time: assert property (p_loop_time) else $error("loopback too early");
  property p_reset_quiet;
    $past(rst) |-> !irq && remoteLoopbackActive == '0 && hreadyout;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("not quiet after reset");
  c_irq: cover property ($rose(irq));
  c_loop: cover property ($rose(remoteLoopbackActive[NCH-1]));
  c_clear: cover property ($fell(channelIrq[0]));
endmodule
bind line_status_event_logic lsel_asserts #(.CODE_CYC_SHORT(CODE_CYC_SHORT), .NCH(NCH)) u_chk (
  .clk(clk), .rst(rst), .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready),
  .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .loopUpCodeMatch(loopUpCodeMatch),
  .remoteLoopbackActive(remoteLoopbackActive), .channelIrq(channelIrq), .irq(irq));
`default_nettype wire

/* verif/test_line_status_event_logic.sv */
`timescale 1ns/1ps
`default_nettype none
module test_line_status_event_logic;
  logic clk = 0, rst = 1, hsel = 0, hwrite = 0;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, rd;
  logic [1:0] htrans = '0;
  logic [2:0] hsize = 3'h2;
  logic hreadyout, hresp, irq;
  logic [3:0] up = '0, down = '0, errHi = '0, patt = '0, txClk = '0, txRun = 4'hf;
  logic [3:0] drv = '0, ais = '0, noSig = '0, loopOn, chIrq;
  int fails = 0, n_compared = 0, cyc = 0;
  int bits[4] = '{4, 2, 1, 0};
  logic [31:0] m;
  always #2.5 clk = ~clk;
  always @(posedge clk) txClk <= txClk ^ txRun;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      fails++;
      final_report();
    end
  end
  line_status_event_logic #(.CODE_CYC_SHORT(20), .CODE_CYC_LONG(50)) DUT (
    .clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .loopUpCodeMatch(up), .loopDownCodeMatch(down), .codeErrorRateHigh(errHi),
    .patternSyncIn(patt), .tx_clock_input(txClk), .driverShortIn(drv), .alarmIndicationIn(ais),
    .noSignalIn(noSig), .remoteLoopbackActive(loopOn), .channelIrq(chIrq), .irq(irq));
  task automatic final_report();
    $display("compared %0d mismatched %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    n_compared++;
    if (seen !== want) begin
      fails++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, want);
    end
  endtask
  // sample before the edge so the combinational ready never races it
  task automatic wait_ready(output logic [31:0] q);
    logic r;
    do begin
      @(negedge clk);
      r = hreadyout;
      q = hrdata;
      @(posedge clk);
    end while (r !== 1'b1);
  endtask
  task automatic xfer(input logic w, input logic [1:0] ch, input logic [5:0] idx,
                      input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= lsel_pkg::HTRANS_NONSEQ;
    hwrite <= w;
    haddr <= {22'h0, ch, idx, 2'h0};
    wait_ready(rd);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_ready(rd);
  endtask
  task automatic rc(input logic [1:0] ch, input logic [5:0] idx, input logic [31:0] want);
    xfer(1'b0, ch, idx, 32'h0);
    check(rd, want);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic src(input int b, input logic v);
    case (b)
      4: patt[0] <= v;
      2: drv[0] <= v;
      1: ais[0] <= v;
      default: noSig[0] <= v;
    endcase
  endtask
  initial begin
    tick(2);
    rst <= 1'b0;
    tick(1);
    for (int c = 0; c < 4; c++) begin
      rc(2'(c), lsel_pkg::IDX_EDGE_SEL, 32'h0);
      rc(2'(c), lsel_pkg::IDX_MASK, 32'h7f);
      rc(2'(c), lsel_pkg::IDX_LIVE, 32'h0);
      rc(2'(c), lsel_pkg::IDX_INT_STAT, 32'h0);
    end
    xfer(1'b1, 2'h2, lsel_pkg::IDX_EDGE_SEL, 32'hff);
    rc(2'h2, lsel_pkg::IDX_EDGE_SEL, 32'h7f);
    xfer(1'b1, 2'h2, lsel_pkg::IDX_LIVE, 32'hff);
    rc(2'h2, lsel_pkg::IDX_LIVE, 32'h0);
    rc(2'h0, 6'h20, 32'h0);
    xfer(1'b1, 2'h0, lsel_pkg::IDX_MASK, 32'h0);
    for (int i = 0; i < 4; i++) begin
      m = 32'h1 << bits[i];
      xfer(1'b1, 2'h0, lsel_pkg::IDX_EDGE_SEL, 32'h0);
      src(bits[i], 1'b1);
      tick(4);
      rc(2'h0, lsel_pkg::IDX_LIVE, m);
      check(32'({chIrq, irq}), 32'h3);
      rc(2'h0, lsel_pkg::IDX_INT_STAT, m);
      rc(2'h0, lsel_pkg::IDX_INT_STAT, 32'h0);
      check(32'(irq), 32'h0);
      src(bits[i], 1'b0);
      tick(4);
      rc(2'h0, lsel_pkg::IDX_INT_STAT, 32'h0);
      xfer(1'b1, 2'h0, lsel_pkg::IDX_EDGE_SEL, m);
      src(bits[i], 1'b1);
      tick(4);
      rc(2'h0, lsel_pkg::IDX_INT_STAT, m);
      src(bits[i], 1'b0);
      tick(4);
      rc(2'h0, lsel_pkg::IDX_INT_STAT, m);
      xfer(1'b1, 2'h0, lsel_pkg::IDX_MASK, m);
      src(bits[i], 1'b1);
      tick(4);
      rc(2'h0, lsel_pkg::IDX_INT_STAT, 32'h0);
      check(32'(irq), 32'h0);
      src(bits[i], 1'b0);
      xfer(1'b1, 2'h0, lsel_pkg::IDX_MASK, 32'h0);
    end
    noSig[0] <= 1'b1;
    tick(4);
    xfer(1'b1, 2'h0, lsel_pkg::IDX_INT_CLEAR, 32'h1);
    rc(2'h0, lsel_pkg::IDX_INT_STAT, 32'h0);
    // stalled transmit clock, checked on both sides of the limit
    xfer(1'b1, 2'h1, lsel_pkg::IDX_MASK, 32'h0);
    txRun[1] <= 1'b0;
    tick(60);
    rc(2'h1, lsel_pkg::IDX_LIVE, 32'h0);
    tick(20);
    rc(2'h1, lsel_pkg::IDX_LIVE, 32'h8);
    rc(2'h1, lsel_pkg::IDX_INT_STAT, 32'h8);
    txRun[1] <= 1'b1;
    tick(4);
    rc(2'h1, lsel_pkg::IDX_LIVE, 32'h0);
    xfer(1'b1, 2'h3, lsel_pkg::IDX_MASK, 32'h0);
    up[3] <= 1'b1;
    tick(10);
    rc(2'h3, lsel_pkg::IDX_LIVE, 32'h0);
    tick(15);
    rc(2'h3, lsel_pkg::IDX_LIVE, 32'h40);
    check(32'(loopOn), 32'h8);
    rc(2'h3, lsel_pkg::IDX_LOOP_STAT, 32'h20);
    up[3] <= 1'b0;
    tick(4);
    rc(2'h3, lsel_pkg::IDX_LIVE, 32'h40);
    errHi[3] <= 1'b1;
    tick(4);
    errHi[3] <= 1'b0;
    rc(2'h3, lsel_pkg::IDX_LIVE, 32'h0);
    xfer(1'b1, 2'h3, lsel_pkg::IDX_CTRL, 32'h1);
    down[3] <= 1'b1;
    tick(30);
    rc(2'h3, lsel_pkg::IDX_LIVE, 32'h0);
    tick(30);
    rc(2'h3, lsel_pkg::IDX_LIVE, 32'h20);
    check(32'(loopOn), 32'h0);
    rc(2'h3, lsel_pkg::IDX_INT_STAT, 32'h60);
    final_report();
  end
endmodule
`default_nettype wire
